// ---- duc_pkg.sv ----
package duc_pkg;
  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_CHAN_A_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_CHAN_B_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_CHAN_A_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CHAN_B_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_OUTPUT_PIN_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_AUXILIARY_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_OUTPUT_LATCH = 8'h18;
  localparam logic [7:0] ADDR_CHAN_A_MODE = 8'h1c;
  localparam logic [7:0] ADDR_CHAN_B_MODE = 8'h20;
  localparam logic [7:0] ADDR_AUX_STATUS = 8'h24;
  // Command byte fields
  localparam int CMD_RX_ON = 0;
  localparam int CMD_RX_OFF = 1;
  localparam int CMD_TX_ON = 2;
  localparam int CMD_TX_OFF = 3;
  localparam int CMD_MISC_LO = 4;
  // Miscellaneous command codes
  localparam logic [2:0] MISC_NONE = 3'h0;
  localparam logic [2:0] MISC_RX_RESET = 3'h2;
  localparam logic [2:0] MISC_TX_RESET = 3'h3;
  localparam logic [2:0] MISC_ERR_RESET = 3'h4;
  // Mode byte: error mode bit position
  localparam int MODE_ERR_BLOCK = 5;
  // Auxiliary control: rate table select bit
  localparam int AUX_RATE_SET = 7;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // Receive FIFO depth
  localparam int RX_DEPTH = 4;
endpackage : duc_pkg

// ---- duc_channel.sv ----
`timescale 1ns/1ps
// One receive/transmit channel: enables, 4-deep receive FIFO with error tags, status
module duc_channel
  import duc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Command write
  input wire logic cmd_we,
  input wire logic [7:0] cmd_byte,
  input wire logic err_block_mode,
  // Received character stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_break,
  input wire logic rx_framing,
  input wire logic rx_parity,
  input wire logic rx_pop,
  // Transmit side
  input wire logic tx_holding_free,
  input wire logic tx_shift_empty,
  // Results
  output logic [7:0] status,
  output logic [7:0] rx_head,
  output logic rx_enabled,
  output logic tx_enabled
);
  logic [10:0] fifo_q [RX_DEPTH];
  logic [2:0] count_q, count_d;
  logic [1:0] rd_q, wr_q;
  logic overrun_q, rx_en_q, tx_en_q;
  logic [2:0] block_q;
  logic [2:0] misc;
  logic rx_reset, err_reset, push, pop, full, avail;
  logic [2:0] head_flags;

  // Command decode: one-shot bits and misc code
  assign misc = cmd_we ? cmd_byte[6:CMD_MISC_LO] : MISC_NONE;
  assign rx_reset = (misc == MISC_RX_RESET);
  assign err_reset = (misc == MISC_ERR_RESET);
  assign full = (count_q == 3'(RX_DEPTH));
  assign avail = (count_q != 3'h0);
  assign push = rx_valid && rx_en_q && !full;
  assign pop = rx_pop && avail;
  assign count_d = count_q + 3'(push) - 3'(pop);
  // Error flags: head entry in char mode, sticky accumulation in block mode
  assign head_flags = avail ? fifo_q[rd_q][10:8] : 3'h0;
  assign status = {(err_block_mode ? block_q : head_flags), overrun_q,
                   tx_shift_empty, tx_holding_free, full, avail};
  // Empty fifo shows zero so never-written slots stay off the pins
  assign rx_head = avail ? fifo_q[rd_q][7:0] : 8'h00;
  assign rx_enabled = rx_en_q;
  assign tx_enabled = tx_en_q;

  // Enables: clear wins over set when both requested at once
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (clk_en && cmd_we) begin
      if (cmd_byte[CMD_TX_OFF]) tx_en_q <= 1'b0;
      else if (cmd_byte[CMD_TX_ON]) tx_en_q <= 1'b1;
      if (cmd_byte[CMD_RX_OFF] || rx_reset) rx_en_q <= 1'b0;
      else if (cmd_byte[CMD_RX_ON]) rx_en_q <= 1'b1;
    end
  end

  // FIFO storage; tags travel with each character
  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      fifo_q[wr_q] <= {rx_break, rx_framing, rx_parity, rx_char};
    end
    // Push needs a free slot, so it never lands on the head being cleared
    if (clk_en && err_reset && avail) begin
      fifo_q[rd_q][10:8] <= 3'h0;
    end
  end

  // Pointers, count, overrun and block errors
  always_ff @(posedge ref_clk) begin
    if (!nrst || (clk_en && rx_reset)) begin
      rd_q <= 2'h0;
      wr_q <= 2'h0;
      count_q <= 3'h0;
      overrun_q <= 1'b0;
      block_q <= 3'h0;
    end else if (clk_en) begin
      if (push) wr_q <= wr_q + 2'h1;
      if (pop) rd_q <= rd_q + 2'h1;
      count_q <= count_d;
      if (rx_valid && rx_en_q && full) overrun_q <= 1'b1;
      else if (err_reset) overrun_q <= 1'b0;
      // New flags survive an error reset in the same cycle; older ones are cleared
      block_q <= (err_reset ? 3'h0 : block_q)
                 | (push ? {rx_break, rx_framing, rx_parity} : 3'h0);
    end
  end
endmodule : duc_channel

// ---- duc_top.sv ----
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Command bits 3..0 request transmitter off, transmitter on, receiver off, receiver on.
// - Status bits are break, framing, parity, overrun, tx empty, tx ready, fifo full, rx ready.
// - Break, framing and parity flags are stored per receive FIFO entry.
// - In character mode status bits 7..5 come from the oldest FIFO entry, bits 4..0 are live.
// - In character mode stored flags go with the character read; error reset clears the oldest entry's flags and the overrun flag.
// - In block mode error flags accumulate until error reset or receiver reset.
// - Pins 7..4 drive latch bits or transmit ready and receive ready/full signals per config bits.
// - Pin 3 selects latch bit 3, timer output, chan B tx 1x or chan B rx 1x clock.
// - Pin 2 selects latch bit 2, chan A tx 16x, chan A tx 1x or chan A rx 1x clock.
// - Aux control bits 3..0 gate input pin change events onto the change condition.
// - Aux control bit 7 selects the first or second baud rate table.
// - Mode error bit selects character mode when zero and block mode when one.
module duc_top
  import duc_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel A receive stream
  input wire logic a_rx_valid,
  input wire logic [7:0] a_rx_char,
  input wire logic [2:0] a_rx_errs,
  input wire logic a_rx_pop,
  input wire logic a_tx_free,
  input wire logic a_tx_empty,
  // Channel B receive stream
  input wire logic b_rx_valid,
  input wire logic [7:0] b_rx_char,
  input wire logic [2:0] b_rx_errs,
  input wire logic b_rx_pop,
  input wire logic b_tx_free,
  input wire logic b_tx_empty,
  // Clock and timer sources for output pins
  input wire logic timer_out,
  input wire logic chan_a_transmit_clock_16x,
  input wire logic chan_a_transmit_clock,
  input wire logic chan_a_receive_clock,
  input wire logic chan_b_transmit_clock,
  input wire logic chan_b_receive_clock,
  // Input pin change events 3..0
  input wire logic [3:0] input_pin_change,
  // Outputs
  output logic [7:2] out_pins,
  output logic input_change_irq,
  output logic rate_table_sel,
  output logic [7:0] a_rx_head,
  output logic [7:0] b_rx_head,
  output logic [1:0] rx_enables,
  output logic [1:0] tx_enables
);
  logic [7:0] pin_cfg_q, aux_q, latch_q, mode_a_q, mode_b_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, chg_q, rate_q;
  logic [7:2] pins_q, pins_d;
  logic [7:0] head_a_q, head_b_q;
  logic [1:0] rxe_q, txe_q;
  logic [7:0] stat_a, stat_b, head_a, head_b;
  logic rxe_a, rxe_b, txe_a, txe_b;
  logic access, wr, rd, hit;
  logic we_cmd_a, we_cmd_b, pop_a, pop_b;
  logic [7:0] rd_byte;
  logic rdy_a, rdy_b;

  // Address decode; an access gets pready in the cycle after its first access cycle with clk_en high
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : is_addr

  assign access = psel && penable && !pready_q;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign we_cmd_a = clk_en && wr && is_addr(paddr, ADDR_CHAN_A_COMMAND);
  assign we_cmd_b = clk_en && wr && is_addr(paddr, ADDR_CHAN_B_COMMAND);
  assign pop_a = a_rx_pop;
  assign pop_b = b_rx_pop;
  assign hit = is_addr(paddr, ADDR_CHAN_A_COMMAND) || is_addr(paddr, ADDR_CHAN_B_COMMAND)
             || is_addr(paddr, ADDR_CHAN_A_STATUS) || is_addr(paddr, ADDR_CHAN_B_STATUS)
             || is_addr(paddr, ADDR_OUTPUT_PIN_CONFIG) || is_addr(paddr, ADDR_AUXILIARY_CONTROL)
             || is_addr(paddr, ADDR_OUTPUT_LATCH) || is_addr(paddr, ADDR_CHAN_A_MODE)
             || is_addr(paddr, ADDR_CHAN_B_MODE) || is_addr(paddr, ADDR_AUX_STATUS);

  // Channel instances
  duc_channel u_chan_a (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .cmd_we(we_cmd_a), .cmd_byte(pwdata[7:0]),
    .err_block_mode(mode_a_q[MODE_ERR_BLOCK]),
    .rx_valid(a_rx_valid), .rx_char(a_rx_char),
    .rx_break(a_rx_errs[2]), .rx_framing(a_rx_errs[1]), .rx_parity(a_rx_errs[0]),
    .rx_pop(pop_a), .tx_holding_free(a_tx_free), .tx_shift_empty(a_tx_empty),
    .status(stat_a), .rx_head(head_a), .rx_enabled(rxe_a), .tx_enabled(txe_a)
  );

  duc_channel u_chan_b (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .cmd_we(we_cmd_b), .cmd_byte(pwdata[7:0]),
    .err_block_mode(mode_b_q[MODE_ERR_BLOCK]),
    .rx_valid(b_rx_valid), .rx_char(b_rx_char),
    .rx_break(b_rx_errs[2]), .rx_framing(b_rx_errs[1]), .rx_parity(b_rx_errs[0]),
    .rx_pop(pop_b), .tx_holding_free(b_tx_free), .tx_shift_empty(b_tx_empty),
    .status(stat_b), .rx_head(head_b), .rx_enabled(rxe_b), .tx_enabled(txe_b)
  );

  // Read mux; configuration registers read back, command registers read as zero
  assign rd_byte = is_addr(paddr, ADDR_CHAN_A_STATUS) ? stat_a :
                   is_addr(paddr, ADDR_CHAN_B_STATUS) ? stat_b :
                   is_addr(paddr, ADDR_OUTPUT_PIN_CONFIG) ? pin_cfg_q :
                   is_addr(paddr, ADDR_AUXILIARY_CONTROL) ? aux_q :
                   is_addr(paddr, ADDR_OUTPUT_LATCH) ? latch_q :
                   is_addr(paddr, ADDR_CHAN_A_MODE) ? mode_a_q :
                   is_addr(paddr, ADDR_CHAN_B_MODE) ? mode_b_q :
                   is_addr(paddr, ADDR_AUX_STATUS) ? {4'h0, txe_b, txe_a, rxe_b, rxe_a} :
                   RESET_BYTE;

  // Receive ready/full per channel follows the mode's fifo-full select bit
  assign rdy_a = mode_a_q[6] ? stat_a[1] : stat_a[0];
  assign rdy_b = mode_b_q[6] ? stat_b[1] : stat_b[0];

  // Output pin selection
  assign pins_d[7] = pin_cfg_q[7] ? stat_b[2] : latch_q[7];
  assign pins_d[6] = pin_cfg_q[6] ? stat_a[2] : latch_q[6];
  assign pins_d[5] = pin_cfg_q[5] ? rdy_b : latch_q[5];
  assign pins_d[4] = pin_cfg_q[4] ? rdy_a : latch_q[4];
  assign pins_d[3] = (pin_cfg_q[3:2] == 2'h0) ? latch_q[3] :
                     (pin_cfg_q[3:2] == 2'h1) ? timer_out :
                     (pin_cfg_q[3:2] == 2'h2) ? chan_b_transmit_clock : chan_b_receive_clock;
  assign pins_d[2] = (pin_cfg_q[1:0] == 2'h0) ? latch_q[2] :
                     (pin_cfg_q[1:0] == 2'h1) ? chan_a_transmit_clock_16x :
                     (pin_cfg_q[1:0] == 2'h2) ? chan_a_transmit_clock : chan_a_receive_clock;

  // APB response: one wait state, error on unmapped address
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RESET_WORD;
    end else if (clk_en) begin
      pready_q <= access;
      pslverr_q <= access && !hit;
      prdata_q <= rd ? {24'h00_0000, rd_byte} : RESET_WORD;
    end
  end

  // Writable configuration registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pin_cfg_q <= RESET_BYTE;
      aux_q <= RESET_BYTE;
      latch_q <= RESET_BYTE;
      mode_a_q <= RESET_BYTE;
      mode_b_q <= RESET_BYTE;
    end else if (clk_en && wr) begin
      if (is_addr(paddr, ADDR_OUTPUT_PIN_CONFIG)) pin_cfg_q <= pwdata[7:0];
      if (is_addr(paddr, ADDR_AUXILIARY_CONTROL)) aux_q <= pwdata[7:0];
      if (is_addr(paddr, ADDR_OUTPUT_LATCH)) latch_q <= pwdata[7:0];
      if (is_addr(paddr, ADDR_CHAN_A_MODE)) mode_a_q <= pwdata[7:0];
      if (is_addr(paddr, ADDR_CHAN_B_MODE)) mode_b_q <= pwdata[7:0];
    end
  end

  // Registered outputs so pins never glitch on decode
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pins_q <= 6'h00;
      chg_q <= 1'b0;
      rate_q <= 1'b0;
      head_a_q <= RESET_BYTE;
      head_b_q <= RESET_BYTE;
      rxe_q <= 2'h0;
      txe_q <= 2'h0;
    end else if (clk_en) begin
      pins_q <= pins_d;
      chg_q <= |(input_pin_change & aux_q[3:0]);
      rate_q <= aux_q[AUX_RATE_SET];
      head_a_q <= head_a;
      head_b_q <= head_b;
      rxe_q <= {rxe_b, rxe_a};
      txe_q <= {txe_b, txe_a};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign out_pins = pins_q;
  assign input_change_irq = chg_q;
  assign rate_table_sel = rate_q;
  assign a_rx_head = head_a_q;
  assign b_rx_head = head_b_q;
  assign rx_enables = rxe_q;
  assign tx_enables = txe_q;
endmodule : duc_top

// ---- duc_properties.sv ----
`timescale 1ns/1ps
// Port-level checks on bus answers, enables, status and pin muxing
module duc_props
  import duc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources
  input wire logic a_tx_free,
  input wire logic a_tx_empty,
  input wire logic timer_out,
  input wire logic [3:0] input_pin_change,
  // Results
  input wire logic [7:2] out_pins,
  input wire logic input_change_irq,
  input wire logic rate_table_sel,
  input wire logic [1:0] rx_enables
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Accepted access decode
  wire logic take = psel && penable && clk_en && !pready;
  wire logic wr_cmd_a = take && pwrite && paddr == ADDR_CHAN_A_COMMAND;
  wire logic wr_aux = take && pwrite && paddr == ADDR_AUXILIARY_CONTROL;
  logic [7:0] aux_q;
  logic [7:0] cfg_q;
  // Shadows of aux and pin config, which show at the ports only on a bus read
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      aux_q <= RESET_BYTE;
      cfg_q <= RESET_BYTE;
    end else if (take && pwrite) begin
      if (paddr == ADDR_AUXILIARY_CONTROL) aux_q <= pwdata[7:0];
      if (paddr == ADDR_OUTPUT_PIN_CONFIG) cfg_q <= pwdata[7:0];
    end
  end
  sequence s_read_a;
    take && !pwrite && paddr == ADDR_CHAN_A_STATUS;
  endsequence
  property p_answer; take |=> pready; endproperty
  property p_slverr; pslverr |-> pready; endproperty
  // Enable flop plus output register: new value shows two edges after the write
  property p_rx_en;
    wr_cmd_a |-> ##2 rx_enables[0] ==
      (($past(pwdata[1], 2) || $past(pwdata[6:4], 2) == MISC_RX_RESET)
      ? 1'b0 : ($past(pwdata[0], 2) || $past(rx_enables[0])));
  endproperty
  property p_status; s_read_a |=> prdata[3:2] == $past({a_tx_empty, a_tx_free}); endproperty
  property p_rate;
    wr_aux |-> ##2 rate_table_sel == $past(pwdata[AUX_RATE_SET], 2);
  endproperty
  property p_pin3;
    cfg_q[3:2] == 2'b01 && $past(cfg_q[3:2]) == 2'b01 |-> out_pins[3] == $past(timer_out);
  endproperty
  property p_pin6; cfg_q[6] && $past(cfg_q[6]) |-> out_pins[6] == $past(a_tx_free); endproperty
  property p_irq;
    $rose(input_change_irq) |-> ($past(input_pin_change) & $past(aux_q[3:0])) != 4'h0;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after access");
  a_slverr: assert property (p_slverr) else $error("error flag without ready");
  a_rx_en: assert property (p_rx_en) else $error("receiver enable wrong");
  a_status: assert property (p_status) else $error("live status bits wrong");
  a_rate: assert property (p_rate) else $error("rate table select wrong");
  a_pin3: assert property (p_pin3) else $error("pin 3 not timer");
  a_pin6: assert property (p_pin6) else $error("pin 6 not tx free");
  a_irq: assert property (p_irq) else $error("change flag without enabled event");
endmodule : duc_props

bind duc_top duc_props u_props (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .a_tx_free(a_tx_free),
  .a_tx_empty(a_tx_empty), .timer_out(timer_out), .input_pin_change(input_pin_change),
  .out_pins(out_pins), .input_change_irq(input_change_irq),
  .rate_table_sel(rate_table_sel), .rx_enables(rx_enables));

// ---- duc_host.sv ----
`timescale 1ns/1ps
// APB master standing in for the host processor
module duc_host
  import duc_pkg::*;
(
  // Clock and answer
  input wire logic ref_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Request
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0000_0000
);
  // One transfer; request held until pready is seen at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    // Command top bit always sent as zero
    pwdata <= (a == ADDR_CHAN_A_COMMAND || a == ADDR_CHAN_B_COMMAND) ? d & 32'h0000_007f : d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // No cycle limit here; the bench watchdog ends a hung wait
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : duc_host

// ---- dual_uart_command_status_regs_test.sv ----
`timescale 1ns/1ps
// Bench driving commands, receive stream and pin sources
module dual_uart_command_status_regs_test
  import duc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq, rsel;
  logic [7:0] paddr, a_head, b_head;
  logic [31:0] pwdata, prdata;
  logic a_rx_valid = 1'b0;
  logic a_rx_pop = 1'b0;
  logic [7:0] a_rx_char = 8'h00;
  logic [2:0] a_rx_errs = 3'h0;
  logic a_tx_free = 1'b1, a_tx_empty = 1'b0, b_tx_free = 1'b0, b_tx_empty = 1'b1;
  logic timer_out = 1'b0, a16 = 1'b1, atx = 1'b0, arx = 1'b1, btx = 1'b1, brx = 1'b0;
  logic [3:0] ipc = 4'h0;
  logic [7:2] out_pins;
  logic [1:0] rx_en, tx_en;
  int fails = 0;
  int comparisons = 0;
  initial forever #5 ref_clk = ~ref_clk;
  duc_host host (.ref_clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // Channel B stream tied off; its pin paths still see b_tx_free
  duc_top dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .a_rx_valid(a_rx_valid), .a_rx_char(a_rx_char),
    .a_rx_errs(a_rx_errs), .a_rx_pop(a_rx_pop), .a_tx_free(a_tx_free),
    .a_tx_empty(a_tx_empty), .b_rx_valid(1'b0), .b_rx_char(8'h00), .b_rx_errs(3'h0),
    .b_rx_pop(1'b0), .b_tx_free(b_tx_free), .b_tx_empty(b_tx_empty), .timer_out(timer_out),
    .chan_a_transmit_clock_16x(a16), .chan_a_transmit_clock(atx),
    .chan_a_receive_clock(arx), .chan_b_transmit_clock(btx), .chan_b_receive_clock(brx),
    .input_pin_change(ipc), .out_pins(out_pins), .input_change_irq(irq),
    .rate_table_sel(rsel), .a_rx_head(a_head), .b_rx_head(b_head), .rx_enables(rx_en),
    .tx_enables(tx_en));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
  endtask : rdc
  // Let registered outputs land before sampling
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  task push(input logic [7:0] c, input logic [2:0] e);
    @(posedge ref_clk);
    a_rx_valid <= 1'b1;
    a_rx_char <= c;
    a_rx_errs <= e;
    @(posedge ref_clk);
    a_rx_valid <= 1'b0;
  endtask : push
  task pop;
    @(posedge ref_clk);
    a_rx_pop <= 1'b1;
    @(posedge ref_clk);
    a_rx_pop <= 1'b0;
  endtask : pop
  task pulse(input logic [3:0] v);
    @(posedge ref_clk);
    ipc <= v;
    @(posedge ref_clk);
    ipc <= 4'h0;
    // Change flag stands one cycle only, so look right after it lands
    #1;
  endtask : pulse
  // Enable table: {rx, tx} after each command on channel A
  task t_cmd;
    logic [7:0] cmd [6] = '{8'h05, 8'h00, 8'h0a, 8'h0f, 8'h01, 8'h04};
    logic [1:0] ex [6] = '{2'b11, 2'b11, 2'b00, 2'b00, 2'b10, 2'b11};
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CHAN_A_COMMAND, 32'(cmd[i]));
      settle;
      check(32'({rx_en[0], tx_en[0]}), 32'(ex[i]));
    end
    wr(ADDR_CHAN_B_COMMAND, 32'h0000_0085);
    settle;
    check(32'({rx_en, tx_en}), 32'h0000_000f);
    wr(ADDR_CHAN_B_COMMAND, 32'h0000_000a);
    settle;
    check(32'({rx_en, tx_en}), 32'h0000_0005);
    $display("t_cmd finished");
  endtask : t_cmd
  task t_fifo;
    wr(ADDR_CHAN_A_MODE, 32'h0000_0000);
    push(8'h11, 3'b101);
    push(8'h22, 3'b010);
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_00a5);
    check(32'(a_head), 32'h0000_0011);
    pop;
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_0045);
    pop;
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_0004);
    for (int i = 0; i < 5; i++) push(8'(i), 3'b000);
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_0017);
    wr(ADDR_CHAN_A_COMMAND, 32'h0000_0040);
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_0007);
    wr(ADDR_CHAN_A_COMMAND, 32'h0000_0020);
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_0004);
    check(32'(rx_en[0]), 32'h0000_0000);
    $display("t_fifo finished");
  endtask : t_fifo
  // Block mode keeps flags after their characters leave
  task t_block;
    wr(ADDR_CHAN_A_MODE, 32'h0000_0020);
    wr(ADDR_CHAN_A_COMMAND, 32'h0000_0001);
    push(8'h33, 3'b001);
    push(8'h44, 3'b100);
    pop;
    pop;
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_00a4);
    wr(ADDR_CHAN_A_COMMAND, 32'h0000_0040);
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_0004);
    $display("t_block finished");
  endtask : t_block
  task t_pins;
    logic [3:0] s3;
    logic [3:0] s2;
    s3 = {brx, btx, timer_out, 1'b1};
    s2 = {arx, atx, a16, 1'b0};
    wr(ADDR_OUTPUT_LATCH, 32'h0000_00a8);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_OUTPUT_PIN_CONFIG, 32'(k * 5));
      settle;
      check(32'(out_pins[3]), 32'(s3[k]));
      check(32'(out_pins[2]), 32'(s2[k]));
      if (k == 0) check(32'(out_pins), 32'h0000_002a);
    end
    push(8'h55, 3'b000);
    wr(ADDR_OUTPUT_PIN_CONFIG, 32'h0000_00f0);
    settle;
    check(32'(out_pins[7:4]), 32'({b_tx_free, a_tx_free, 2'b01}));
    $display("t_pins finished");
  endtask : t_pins
  task t_aux;
    logic [31:0] r;
    logic e;
    wr(ADDR_AUXILIARY_CONTROL, 32'h0000_0082);
    settle;
    check(32'(rsel), 32'h0000_0001);
    pulse(4'b0001);
    check(32'(irq), 32'h0000_0000);
    pulse(4'b0010);
    check(32'(irq), 32'h0000_0001);
    wr(ADDR_AUXILIARY_CONTROL, 32'h0000_0000);
    settle;
    check(32'(rsel), 32'h0000_0000);
    host.xfer(1'b0, 8'h40, 32'h0000_0000, r, e);
    check(r, 32'h0000_0000);
    check(32'(e), 32'h0000_0001);
    $display("t_aux finished");
  endtask : t_aux
  // Enable low: stream push and pop must both be ignored
  task t_freeze;
    @(posedge ref_clk);
    en <= 1'b0;
    push(8'h66, 3'b111);
    pop;
    @(posedge ref_clk);
    en <= 1'b1;
    rdc(ADDR_CHAN_A_STATUS, 32'h0000_0005);
    check(32'(a_head), 32'h0000_0055);
    check(32'(b_head), 32'h0000_0000);
    $display("t_freeze finished");
  endtask : t_freeze
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // Watchdog of 10000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fails++;
    results;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    t_cmd;
    t_fifo;
    t_block;
    t_pins;
    t_aux;
    t_freeze;
    results;
  end
endmodule : dual_uart_command_status_regs_test
